// file: mst_pkg.sv
// shared constants for the modem status and test register link
package mst_pkg;
  localparam int          ADDR_W         = 6;
  localparam int          DATA_W         = 16;
  localparam int          FRAME_BITS     = 24;
  localparam int          CMD_BITS       = 8;
  localparam int          FRAME_RD_BIT   = 23;
  localparam int          SYNC_N         = 10;
  localparam logic [9:0]  SYNC_RST       = 10'h002;
  localparam logic [4:0]  CNT_CMD_LAST   = 5'h07;
  localparam logic [4:0]  CNT_FRAME_LAST = 5'h17;
  localparam logic [4:0]  CNT_FRAME      = 5'h18;
  localparam logic [4:0]  CNT_CMD        = 5'h08;
  // transceiver register offsets
  localparam logic [5:0]  REG_PIN_IN     = 6'h28;
  localparam logic [5:0]  REG_VERSION    = 6'h2c;
  localparam logic [5:0]  REG_RX_STATUS  = 6'h2d;
  localparam logic [5:0]  REG_TS_HIGH    = 6'h2e;
  localparam logic [5:0]  REG_TS_LOW     = 6'h2f;
  localparam logic [5:0]  REG_CONT_TEST  = 6'h30;
  localparam logic [5:0]  REG_MOD_TEST   = 6'h31;
  localparam logic [5:0]  REG_TUNING     = 6'h34;
  // field positions and values
  localparam int          PIN_LSB        = 8;
  localparam int          VER_LSB        = 7;
  localparam int          CONT_BIT       = 15;
  localparam int          MOD_LSB        = 3;
  localparam int          MOD_W          = 3;
  localparam logic [2:0]  MOD_NORMAL     = 3'h0;
  localparam logic [2:0]  MOD_CARRIER    = 3'h1;
  localparam logic [1:0]  CCA_ENERGY     = 2'h2;
  localparam logic [15:0] TUNE_RST       = 16'hfec2;
  localparam logic [15:0] TUNE_NEW       = 16'hfec6;
  localparam logic [15:0] MOD_WORD_NORM  = 16'ha0c0;
  localparam logic [15:0] MOD_WORD_TEST  = 16'ha0c8;
  // serial clock timing
  localparam int          CLK_NS         = 4;
  localparam int          SCLK_HALF_NS   = 64;
  localparam int          SCLK_HALF_CYC  = SCLK_HALF_NS / CLK_NS;
  // host register map
  localparam logic [7:0]  H_CTRL         = 8'h00;
  localparam logic [7:0]  H_WDATA        = 8'h04;
  localparam logic [7:0]  H_STATUS       = 8'h08;
  localparam logic [7:0]  H_RDATA        = 8'h0c;
  localparam logic [7:0]  H_IRQ_STAT     = 8'h10;
  localparam logic [7:0]  H_IRQ_MASK     = 8'h14;
  localparam int          CTRL_RD_BIT    = 8;
  localparam int          CTRL_INIT_BIT  = 9;
  localparam int          CTRL_TEST_BIT  = 10;
  localparam int          IRQ_W          = 2;
  localparam int          IRQ_DONE       = 0;
  localparam int          IRQ_DEV        = 1;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_GAP   = 3'b100
  } mst_state_t;
endpackage

// file: mst_spi_if.sv
// serial link between host controller and transceiver register bank
`timescale 1ns/1ps
interface mst_spi_if;
  logic sclk;
  logic ce_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic dev_irq;
  modport device (input sclk, input ce_n, input mosi, output miso, output miso_oe,
                  output dev_irq);
  modport host (output sclk, output ce_n, output mosi, input miso, input miso_oe,
                input dev_irq);
endinterface

// file: mst_device.sv
// transceiver status and test register bank behind the serial link
`timescale 1ns/1ps
module mst_device
  import mst_pkg::*;
#(
  parameter logic [8:0] VERSION_CODE = 9'h0a5 // arbitrary value
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  mst_spi_if.device        link,
  input  wire logic [7:1]  pin_level,
  input  wire logic [7:1]  pin_drive_enable,
  input  wire logic [7:1]  pin_sense_enable,
  input  wire logic [1:0]  cca_type,
  input  wire logic [7:0]  cca_energy_avg,
  input  wire logic [7:0]  cca_corr_avg,
  input  wire logic        sfd_detect,
  input  wire logic [6:0]  frame_length_field,
  input  wire logic        payload_start,
  input  wire logic [23:0] event_count,
  input  wire logic        stream_mode,
  input  wire logic        rx_word_ready,
  input  wire logic        irq_status_read,
  input  wire logic        op_start,
  input  wire logic        op_end,
  input  wire logic        op_abort,
  output logic             continuous_mode,
  output logic             op_active,
  output logic [2:0]       modulator_test_select,
  output logic             carrier_only,
  output logic [15:0]      tuning_value,
  output logic             rx_stream_irq
);

  // input synchronisers: pins, sclk, ce_n, mosi
  logic [SYNC_N-1:0] sync_in;
  logic [SYNC_N-1:0] s1_r;
  logic [SYNC_N-1:0] s2_r;
  logic [SYNC_N-1:0] s3_r;
  logic [SYNC_N-1:0] lvl_r;
  logic [SYNC_N-1:0] prev_r;

  assign sync_in = {pin_level, link.sclk, link.ce_n, link.mosi};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_r[gi]   <= SYNC_RST[gi];
          s2_r[gi]   <= SYNC_RST[gi];
          s3_r[gi]   <= SYNC_RST[gi];
          lvl_r[gi]  <= SYNC_RST[gi];
          prev_r[gi] <= SYNC_RST[gi];
        end else begin
          s1_r[gi]   <= sync_in[gi];
          s2_r[gi]   <= s1_r[gi];
          s3_r[gi]   <= s2_r[gi];
          prev_r[gi] <= lvl_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            lvl_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

  wire       mosi_lvl  = lvl_r[0];
  wire       active    = ~lvl_r[1];
  wire       sclk_rise = lvl_r[2] & ~prev_r[2];
  wire       sclk_fall = ~lvl_r[2] & prev_r[2];
  wire [7:1] pin_sync  = lvl_r[9:3];

  // serial frame: read flag, spare, 6-bit address, 16-bit data
  logic [4:0]  cnt_r;
  logic [22:0] rx_r;
  logic [15:0] tx_r;

  wire [7:0]  cmd_now   = {rx_r[6:0], mosi_lvl};
  wire [5:0]  rd_addr   = cmd_now[ADDR_W-1:0];
  wire        load_rd   = active & sclk_rise & (cnt_r == CNT_CMD_LAST) & cmd_now[CMD_BITS-1];
  wire        wr_stb    = active & sclk_rise & (cnt_r == CNT_FRAME_LAST)
                          & ~rx_r[FRAME_RD_BIT-1];
  wire [5:0]  wr_addr   = rx_r[20:15];
  wire [15:0] wr_data   = {rx_r[14:0], mosi_lvl};

  // stored registers
  logic        cont_r;
  logic [2:0]  mod_r;
  logic [15:0] tune_r;
  logic [6:0]  rx_len_r;
  logic [23:0] ts_r;
  logic        flag_r;
  logic        first_pend_r;
  logic        op_active_r;

  // read decode
  wire hit_pin  = (rd_addr == REG_PIN_IN);
  wire hit_ver  = (rd_addr == REG_VERSION);
  wire hit_stat = (rd_addr == REG_RX_STATUS);
  wire hit_tsh  = (rd_addr == REG_TS_HIGH);
  wire hit_tsl  = (rd_addr == REG_TS_LOW);
  wire hit_cont = (rd_addr == REG_CONT_TEST);
  wire hit_mod  = (rd_addr == REG_MOD_TEST);
  wire hit_tune = (rd_addr == REG_TUNING);

  wire [7:1]  pin_vis   = pin_sync & ~pin_drive_enable & pin_sense_enable;
  wire [7:0]  cca_sel   = (cca_type == CCA_ENERGY) ? cca_energy_avg : cca_corr_avg;
  wire [15:0] w_pin     = 16'(pin_vis) << PIN_LSB;
  wire [15:0] w_ver     = 16'(VERSION_CODE) << VER_LSB;
  wire [15:0] w_stat    = {cca_sel, 1'b0, rx_len_r};
  wire [15:0] w_tsh     = 16'(ts_r[23:16]);
  wire [15:0] w_tsl     = ts_r[15:0];
  wire [15:0] w_cont    = 16'(cont_r) << CONT_BIT;
  wire [15:0] w_mod     = 16'(mod_r) << MOD_LSB;

  wire [15:0] rd_data   = ({16{hit_pin}}  & w_pin)  |
                          ({16{hit_ver}}  & w_ver)  |
                          ({16{hit_stat}} & w_stat) |
                          ({16{hit_tsh}}  & w_tsh)  |
                          ({16{hit_tsl}}  & w_tsl)  |
                          ({16{hit_cont}} & w_cont) |
                          ({16{hit_mod}}  & w_mod)  |
                          ({16{hit_tune}} & tune_r);

  // serial shift engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      rx_r  <= '0;
      tx_r  <= '0;
    end else if (!active) begin
      cnt_r <= '0;
      tx_r  <= '0;
    end else begin
      if (sclk_rise && cnt_r != CNT_FRAME) begin
        rx_r  <= {rx_r[21:0], mosi_lvl};
        cnt_r <= cnt_r + 5'h01;
      end
      if (load_rd) begin
        tx_r <= rd_data;
      end else if (sclk_fall && cnt_r > CNT_CMD) begin
        tx_r <= {tx_r[14:0], 1'b0};
      end
    end
  end

  assign link.miso    = tx_r[DATA_W-1];
  assign link.miso_oe = active;

  // writable registers, read-only offsets ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cont_r <= 1'b0;
      mod_r  <= MOD_NORMAL;
      tune_r <= TUNE_RST;
    end else if (wr_stb) begin
      if (wr_addr == REG_CONT_TEST) begin
        cont_r <= wr_data[CONT_BIT];
      end
      if (wr_addr == REG_MOD_TEST) begin
        mod_r <= wr_data[MOD_LSB +: MOD_W];
      end
      if (wr_addr == REG_TUNING) begin
        tune_r <= wr_data;
      end
    end
  end

  // receive captures
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_len_r <= '0;
      ts_r     <= '0;
    end else begin
      if (sfd_detect) begin
        rx_len_r <= frame_length_field;
      end
      if (payload_start) begin
        ts_r <= event_count;
      end
    end
  end

  // stream interrupt: first for length, then per data word
  wire set_first = stream_mode & sfd_detect;
  wire set_word  = stream_mode & rx_word_ready & ~set_first;
  wire stat_rd   = load_rd & hit_stat;
  wire flag_clr  = irq_status_read | (stat_rd & first_pend_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r       <= 1'b0;
      first_pend_r <= 1'b0;
    end else begin
      if (set_first || set_word) begin
        flag_r <= 1'b1;
      end else if (flag_clr) begin
        flag_r <= 1'b0;
      end
      if (set_first) begin
        first_pend_r <= 1'b1;
      end else if (set_word || flag_clr) begin
        first_pend_r <= 1'b0;
      end
    end
  end

  // operation hold under continuous test
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_active_r <= 1'b0;
    end else if (op_abort) begin
      op_active_r <= 1'b0;
    end else if (op_start) begin
      op_active_r <= 1'b1;
    end else if (op_end && !cont_r) begin
      op_active_r <= 1'b0;
    end
  end

  assign continuous_mode       = cont_r;
  assign op_active             = op_active_r;
  assign modulator_test_select = mod_r;
  assign carrier_only          = (mod_r == MOD_CARRIER);
  assign tuning_value          = tune_r;
  assign rx_stream_irq         = flag_r;
  assign link.dev_irq          = flag_r;

endmodule

// file: mst_host.sv
// host serial master with axi4-lite command registers
`timescale 1ns/1ps
module mst_host
  import mst_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  mst_spi_if.host          link
);

  // miso and device interrupt synchronisers
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  logic [1:0] lvl_r;
  logic       dev_prev_r;
  wire  [1:0] sync_in = {link.dev_irq, link.miso};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_r[gi]  <= 1'b0;
          s2_r[gi]  <= 1'b0;
          s3_r[gi]  <= 1'b0;
          lvl_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= sync_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            lvl_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

  // axi write path
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;

  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = 2'h0;
  assign s_axi_rdata   = rdata_r;

  wire        wr_do  = aw_hold_r & w_hold_r & ~bvalid_r;
  wire [31:0] wmask  = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] wbits  = wdata_r & wmask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // command registers and link engine
  mst_state_t  st_r;
  logic [15:0] wreg_r;
  logic [15:0] rreg_r;
  logic [IRQ_W-1:0] stat_r;
  logic [IRQ_W-1:0] mask_r;
  logic [1:0]  init_left_r;
  logic        init_test_r;
  logic [23:0] tx_sh_r;
  logic [15:0] rx_sh_r;
  logic [4:0]  bits_r;
  logic [15:0] div_r;
  logic        sclk_r;
  logic        ce_n_r;

  wire idle    = (st_r == ST_IDLE);
  wire busy    = ~idle | (init_left_r != 2'h0);
  wire tick    = (div_r == 16'(HALF_CYC - 1));
  wire ctrl_wr = wr_do & (awaddr_r == H_CTRL) & wstrb_r[0] & ~busy;
  wire init_go = ctrl_wr & wdata_r[CTRL_INIT_BIT];
  wire user_go = ctrl_wr & ~wdata_r[CTRL_INIT_BIT];
  wire auto_go = idle & (init_left_r != 2'h0);
  wire [15:0] init_mod = init_test_r ? MOD_WORD_TEST : MOD_WORD_NORM;
  wire [23:0] user_fr  = {wdata_r[CTRL_RD_BIT], 1'b0, wdata_r[ADDR_W-1:0], wreg_r};
  wire [23:0] init_fr  = (init_left_r == 2'h2) ? {2'b00, REG_MOD_TEST, init_mod}
                                               : {2'b00, REG_TUNING, TUNE_NEW};
  wire done    = (st_r == ST_GAP) & tick & (init_left_r == 2'h0);
  wire dev_up  = lvl_r[1] & ~dev_prev_r;
  wire [IRQ_W-1:0] ev  = {dev_up, done};
  wire [IRQ_W-1:0] clr = (wr_do && awaddr_r == H_IRQ_STAT) ? wbits[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r        <= ST_IDLE;
      wreg_r      <= '0;
      rreg_r      <= '0;
      stat_r      <= '0;
      mask_r      <= '0;
      init_left_r <= 2'h0;
      init_test_r <= 1'b0;
      tx_sh_r     <= '0;
      rx_sh_r     <= '0;
      bits_r      <= '0;
      div_r       <= '0;
      sclk_r      <= 1'b0;
      ce_n_r      <= 1'b1;
      dev_prev_r  <= 1'b0;
    end else begin
      dev_prev_r <= lvl_r[1];
      stat_r     <= (stat_r & ~clr) | ev;
      if (wr_do && awaddr_r == H_WDATA) begin
        wreg_r <= (wreg_r & ~wmask[15:0]) | wbits[15:0];
      end
      if (wr_do && awaddr_r == H_IRQ_MASK) begin
        mask_r <= (mask_r & ~wmask[IRQ_W-1:0]) | wbits[IRQ_W-1:0];
      end
      if (init_go) begin
        init_left_r <= 2'h2;
        init_test_r <= wdata_r[CTRL_TEST_BIT];
      end
      div_r <= (idle || tick) ? 16'h0000 : div_r + 16'h0001;
      unique case (st_r)
        ST_IDLE: begin
          if (user_go || auto_go) begin
            tx_sh_r <= user_go ? user_fr : init_fr;
            ce_n_r  <= 1'b0;
            bits_r  <= '0;
            st_r    <= ST_SHIFT;
          end
          if (auto_go) begin
            init_left_r <= init_left_r - 2'h1;
          end
        end
        ST_SHIFT: begin
          if (tick && !sclk_r) begin
            sclk_r  <= 1'b1;
            rx_sh_r <= {rx_sh_r[14:0], lvl_r[0]};
            bits_r  <= bits_r + 5'h01;
          end else if (tick) begin
            sclk_r <= 1'b0;
            if (bits_r == CNT_FRAME) begin
              ce_n_r <= 1'b1;
              st_r   <= ST_GAP;
            end else begin
              tx_sh_r <= {tx_sh_r[22:0], 1'b0};
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            rreg_r <= rx_sh_r;
            st_r   <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // axi read path
  wire [31:0] rd_mux = (s_axi_araddr == H_STATUS)   ? 32'(busy)   :
                       (s_axi_araddr == H_WDATA)    ? 32'(wreg_r) :
                       (s_axi_araddr == H_RDATA)    ? 32'(rreg_r) :
                       (s_axi_araddr == H_IRQ_STAT) ? 32'(stat_r) :
                       (s_axi_araddr == H_IRQ_MASK) ? 32'(mask_r) : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign irq       = |(stat_r & mask_r);
  assign link.sclk = sclk_r;
  assign link.ce_n = ce_n_r;
  assign link.mosi = tx_sh_r[FRAME_BITS-1];

endmodule

// file: mst_link_asserts.sv
// protocol checker for the serial link between host and device
`timescale 1ns/1ps
module mst_link_asserts #(
  parameter int HALF_CYC = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk,
  input wire logic ce_n,
  input wire logic mosi,
  input wire logic miso_oe
);
  logic       sclk_q;
  logic [7:0] hcnt;
  logic [7:0] gcnt;
  logic [4:0] bits;
  wire        sclk_rise = sclk && !sclk_q;
  wire        gap_seen  = ce_n && (gcnt != 8'h00);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_q <= 1'b0;
      hcnt   <= 8'h00;
      gcnt   <= 8'h00;
      bits   <= 5'h00;
    end else begin
      sclk_q <= sclk;
      hcnt   <= (sclk != sclk_q) ? 8'h00 : hcnt + 8'h01;
      gcnt   <= !ce_n ? 8'h00 : ((gcnt == 8'hff) ? gcnt : gcnt + 8'h01);
      bits   <= gap_seen ? 5'h00 : ((sclk_rise && !ce_n) ? bits + 5'h01 : bits);
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_SCLK_IDLE: assert property (ce_n && $past(ce_n) |-> !sclk)
    else $error("serial clock moved outside a frame");
  AST_HIGH_PHASE: assert property (sclk_q && !sclk |-> hcnt == HALF_CYC - 1)
    else $error("serial clock high phase has wrong length");
  AST_MOSI_HOLD: assert property (sclk && sclk_q |-> $stable(mosi))
    else $error("host data changed while serial clock high");
  AST_FRAME_LEN: assert property ($rose(ce_n) |-> bits == 5'd24)
    else $error("frame did not carry 24 clock rises");
  AST_GAP: assert property ($fell(ce_n) |-> $past(gcnt) >= HALF_CYC - 2)
    else $error("gap between frames too short");
  AST_FIRST_LOW: assert property ($fell(ce_n) |-> !sclk [*8])
    else $error("serial clock rose too early in frame");
  AST_OE_ON: assert property ($fell(ce_n) |-> ##[1:8] miso_oe)
    else $error("device did not drive its data line in frame");
  AST_OE_OFF: assert property (ce_n [*8] |-> !miso_oe)
    else $error("device drives its data line while deselected");
endmodule

// file: modem_status_test_registers_tb_top.sv
// testbench joining host and device over the serial link
`timescale 1ns/1ps
module modem_status_test_registers_tb_top;
  import mst_pkg::*;
  localparam int         HC  = SCLK_HALF_CYC;
  localparam logic [8:0] VER = 9'h0a5; // arbitrary value
  typedef struct {logic [5:0] a; logic [1:0] k; logic [15:0] d; logic [15:0] e;} mst_row_t;
  mst_row_t rows[13] = '{'{6'h34, 2'd0, 16'h0, 16'hfec2}, '{6'h2c, 2'd0, 16'h0, {VER, 7'h00}},
    '{6'h30, 2'd0, 16'h0, 16'h0}, '{6'h31, 2'd0, 16'h0, 16'h0},
    '{6'h2c, 2'd1, 16'hffff, {VER, 7'h00}}, '{6'h30, 2'd1, 16'hffff, 16'h8000},
    '{6'h31, 2'd1, 16'ha0c8, 16'h0008}, '{6'h31, 2'd1, 16'ha0c0, 16'h0},
    '{6'h34, 2'd1, 16'h1234, 16'h1234}, '{6'h31, 2'd3, 16'h0, 16'h0008},
    '{6'h34, 2'd0, 16'h0, 16'hfec6}, '{6'h31, 2'd2, 16'h0, 16'h0}, '{6'h3f, 2'd0, 16'h0, 16'h0}};
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cca_type = 2'h0;
  logic [7:1]  pin_level = 7'h0, pin_drive_enable = 7'h0, pin_sense_enable = 7'h0;
  logic [7:0]  cca_energy_avg = 8'h0, cca_corr_avg = 8'h0;
  logic [6:0]  frame_length_field = 7'h0, pls = 7'h0;
  logic [23:0] event_count = 24'h0;
  logic        stream_mode = 1'b0, continuous_mode, op_active, carrier_only, rx_stream_irq;
  logic [2:0]  modulator_test_select;
  logic [15:0] tuning_value;
  logic        sfd_detect, payload_start, rx_word_ready, irq_status_read;
  logic        op_start, op_end, op_abort;
  int          mismatches = 0, checks = 0;
  logic [31:0] r;
  assign {op_abort, op_end, op_start, irq_status_read, rx_word_ready, payload_start, sfd_detect} = pls;
  always #2 aclk = ~aclk;
  mst_spi_if link();
  mst_host #(.HALF_CYC(HC)) mst_host_i (.*);
  mst_device #(.VERSION_CODE(VER)) mst_device_i (.*);
  mst_link_asserts #(.HALF_CYC(HC)) mst_link_asserts_i (.aclk(aclk), .aresetn(aresetn),
    .sclk(link.sclk), .ce_n(link.ce_n), .mosi(link.mosi), .miso_oe(link.miso_oe));
  task automatic test_done();
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    mismatches++;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    logic ah, rh;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    mismatches++;
  endtask
  task automatic frm(input logic [31:0] c, input logic [15:0] d);
    logic [31:0] s;
    s = 32'h1;
    axw(H_WDATA, {16'h0000, d});
    axw(H_CTRL, c);
    for (int n = 0; n < 1000 && s[0]; n++) axr(H_STATUS, s);
    if (s[0] !== 1'b0) mismatches++;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] x);
    frm(32'h100 | {26'h0, a}, 16'h0000);
    axr(H_RDATA, r);
    chk(r, {16'h0000, x});
  endtask
  task automatic pul(input logic [6:0] m);
    @(posedge aclk);
    pls <= m;
    @(posedge aclk);
    pls <= 7'h00;
    repeat (10) @(posedge aclk);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    chk({tuning_value, 12'h0, continuous_mode, op_active, carrier_only, irq}, {TUNE_RST, 16'h0});
    foreach (rows[i]) begin
      if (rows[i].k == 2'd1) frm({26'h0, rows[i].a}, rows[i].d);
      if (rows[i].k[1]) frm({21'h0, rows[i].k[0], 10'h200}, 16'h0000);
      rd(rows[i].a, rows[i].e);
    end
    chk(tuning_value, {16'h0, TUNE_NEW});
    pin_level <= 7'h7f;
    pin_drive_enable <= 7'h03;
    pin_sense_enable <= 7'h7e;
    repeat (8) @(posedge aclk);
    rd(REG_PIN_IN, 16'h7c00);
    cca_type <= CCA_ENERGY;
    cca_energy_avg <= 8'h3c;
    cca_corr_avg <= 8'hc3;
    frame_length_field <= 7'h55;
    event_count <= 24'habcdef;
    pul(7'h03);
    rd(REG_RX_STATUS, 16'h3c55);
    rd(REG_TS_HIGH, 16'h00ab);
    rd(REG_TS_LOW, 16'hcdef);
    cca_type <= 2'h0;
    event_count <= 24'h123456;
    frame_length_field <= 7'h2a;
    rd(REG_TS_LOW, 16'hcdef);
    pul(7'h02);
    rd(REG_TS_HIGH, 16'h0012);
    axw(H_IRQ_MASK, 32'h2);
    axw(H_IRQ_STAT, 32'h3);
    stream_mode <= 1'b1;
    pul(7'h01);
    chk({rx_stream_irq, irq}, 2'b11);
    rd(REG_RX_STATUS, 16'hc32a);
    chk(rx_stream_irq, 1'b0);
    pul(7'h04);
    rd(REG_RX_STATUS, 16'hc32a);
    chk(rx_stream_irq, 1'b1);
    pul(7'h08);
    axw(H_IRQ_STAT, 32'h2);
    chk({rx_stream_irq, irq}, 2'b00);
    frm({26'h0, REG_CONT_TEST}, 16'h8000);
    frm({26'h0, REG_MOD_TEST}, MOD_WORD_TEST);
    chk({continuous_mode, carrier_only, modulator_test_select}, {2'b11, MOD_CARRIER});
    pul(7'h10);
    pul(7'h20);
    chk(op_active, 1'b1);
    pul(7'h40);
    chk(op_active, 1'b0);
    frm({26'h0, REG_CONT_TEST}, 16'h0000);
    pul(7'h10);
    chk(op_active, 1'b1);
    pul(7'h20);
    chk({continuous_mode, op_active}, 2'b00);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    chk({tuning_value, modulator_test_select}, {TUNE_RST, MOD_NORMAL});
    test_done();
  end
  initial begin
    #250000;
    mismatches++;
    test_done();
  end
endmodule
